// *** rtl/bbalu_core.sv ***
// What this block does
// RULE1 - Add-with-carry writes destination plus source plus carry flag; source untouched.
// RULE2 - Plain add writes destination plus source, ignoring carry in.
// RULE3 - Both adds set carry on carry out of bit seven, else clear.
// RULE4 - Both adds set overflow when like-signed operands give opposite-signed result.
// RULE5 - Both adds set half-carry on carry out of bit three.
// RULE6 - Both adds always clear the decimal-adjust flag.
// RULE7 - Both adds set zero on zero result, sign on negative result.
// RULE8 - AND stores one only where both operand bits are one.
// RULE9 - AND sets zero, copies bit 7 to sign, clears overflow, keeps others.
// RULE10 - Bit AND: source bit into bit zero, or source bit zero into bit.
// RULE11 - Bit AND sets zero from result bit, clears sign, keeps C, D, H.
// RULE12 - Bit operand byte: 4-bit register, 3-bit bit index, 1-bit form selector.
// RULE13 - Bit compare sets zero when bits match, clears sign, writes nothing.
// RULE14 - Result and affected flags land together; unaffected flags keep values.
// RULE15 - After reset no result is pending and flags hold until first completion.
//
// Purpose: Execute byte add, add with carry, AND, bit AND and bit compare
// Assumes: Operands arrive with op_valid; one operation per accepted cycle
// Notes: Result and flags appear one cycle after acceptance
`timescale 1ns/100ps
`default_nettype none
module bbalu_core
  import bbalu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire bbalu_pkg::bbalu_op_t op_code,
  input wire logic [7:0] op_dst,
  input wire logic [7:0] op_src,
  input wire logic [7:0] op_bitfield,
  output logic op_ready,
  output logic res_valid,
  output logic res_write,
  output logic [7:0] res_data,
  output logic [3:0] res_reg_addr,
  output logic flag_c,
  output logic flag_z,
  output logic flag_s,
  output logic flag_v,
  output logic flag_d,
  output logic flag_h,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import bbalu_pkg::*;

  logic rst_meta_b;
  logic rst_sync_b;
  logic op_fire;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [2:0] bit_idx;
  logic bit_sel;
  logic next_write;
  logic [7:0] next_data;
  logic next_c;
  logic next_z;
  logic next_s;
  logic next_v;
  logic next_d;
  logic next_h;
  logic next_valid;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  assign op_fire = op_valid && op_ready;
  assign bit_idx = op_bitfield[BBALU_FLD_BIT_HI:BBALU_FLD_BIT_LO]; // [RULE12]
  assign bit_sel = op_bitfield[BBALU_FLD_SEL]; // [RULE12]

  // Carry in only for the carrying variant
  assign sum9 = {1'b0, op_dst} + {1'b0, op_src} + {8'h00, (op_code == BBALU_OP_ADC) && flag_c}; // [RULE1] [RULE2]
  assign sum5 = {1'b0, op_dst[3:0]} + {1'b0, op_src[3:0]} + {4'h0, (op_code == BBALU_OP_ADC) && flag_c};

  // Flags default to held values so unaffected ones never move
  always_comb begin
    next_valid = 1'b1;
    next_write = 1'b1;
    next_data = op_dst;
    next_c = flag_c; // [RULE14]
    next_z = flag_z;
    next_s = flag_s;
    next_v = flag_v;
    next_d = flag_d;
    next_h = flag_h;
    case (op_code)
      BBALU_OP_ADD, BBALU_OP_ADC: begin
        next_data = sum9[7:0]; // [RULE1] [RULE2]
        next_c = sum9[8]; // [RULE3]
        next_v = (op_dst[7] == op_src[7]) && (sum9[7] != op_dst[7]); // [RULE4]
        next_h = sum5[4]; // [RULE5]
        next_d = 1'b0; // [RULE6]
        next_z = (sum9[7:0] == 8'h00); // [RULE7]
        next_s = sum9[7]; // [RULE7]
      end
      BBALU_OP_AND: begin
        next_data = op_dst & op_src; // [RULE8]
        next_z = ((op_dst & op_src) == 8'h00); // [RULE9]
        next_s = op_dst[7] & op_src[7]; // [RULE9]
        next_v = 1'b0; // [RULE9]
      end
      BBALU_OP_BAND: begin
        // Overflow is left undefined; holding it is the cheapest choice
        if (!bit_sel) begin
          next_data[0] = op_dst[0] & op_src[bit_idx]; // [RULE10]
          next_z = !(op_dst[0] & op_src[bit_idx]); // [RULE11]
        end else begin
          next_data[bit_idx] = op_dst[bit_idx] & op_src[0]; // [RULE10]
          next_z = !(op_dst[bit_idx] & op_src[0]); // [RULE11]
        end
        next_s = 1'b0; // [RULE11]
      end
      BBALU_OP_BIT_COMPARE: begin
        next_write = 1'b0; // [RULE13]
        next_z = (op_dst[0] == op_src[bit_idx]); // [RULE13]
        next_s = 1'b0; // [RULE13]
      end
      default: begin
        next_valid = 1'b0;
        next_write = 1'b0;
      end
    endcase
  end

  // Result and flags land in the same edge
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      res_valid <= 1'b0; // [RULE15]
      res_write <= 1'b0;
      res_data <= 8'h00;
      res_reg_addr <= 4'h0;
    end else begin
      res_valid <= op_fire && next_valid;
      res_write <= op_fire && next_write;
      if (op_fire && next_valid) begin
        res_data <= next_data;
        res_reg_addr <= op_bitfield[BBALU_FLD_REG_HI:BBALU_FLD_REG_LO]; // [RULE12]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      flag_c <= 1'b0;
      flag_z <= 1'b0;
      flag_s <= 1'b0;
      flag_v <= 1'b0;
      flag_d <= 1'b0;
      flag_h <= 1'b0;
    end else if (op_fire && next_valid) begin
      flag_c <= next_c; // [RULE14] [RULE15]
      flag_z <= next_z;
      flag_s <= next_s;
      flag_v <= next_v;
      flag_d <= next_d;
      flag_h <= next_h;
    end
  end

  // Write channel: address and data taken in either order, one write in flight
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BBALU_RESP_OKAY;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == BBALU_CTRL_OFS || aw_addr == BBALU_STATUS_OFS ||
                        aw_addr == BBALU_RESULT_OFS) ? BBALU_RESP_OKAY : BBALU_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Enable gates decode; off stalls the decoder rather than dropping work
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      op_ready <= BBALU_CTRL_EN_RESET;
    end else if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid &&
                 aw_addr == BBALU_CTRL_OFS && w_strb[0]) begin
      op_ready <= w_data[BBALU_CTRL_EN_BIT];
    end
  end

  // Read channel answers one cycle after the address
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= BBALU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= BBALU_RESP_OKAY;
      case (s_axi_araddr)
        BBALU_CTRL_OFS: s_axi_rdata <= {31'h0000_0000, op_ready};
        BBALU_STATUS_OFS: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rdata[BBALU_ST_C] <= flag_c;
          s_axi_rdata[BBALU_ST_Z] <= flag_z;
          s_axi_rdata[BBALU_ST_S] <= flag_s;
          s_axi_rdata[BBALU_ST_V] <= flag_v;
          s_axi_rdata[BBALU_ST_D] <= flag_d;
          s_axi_rdata[BBALU_ST_H] <= flag_h;
          s_axi_rdata[BBALU_ST_RES] <= res_valid;
        end
        BBALU_RESULT_OFS: s_axi_rdata <= {24'h00_0000, res_data};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= BBALU_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking chk_clk @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_b);

  chk_adc_sum: assert property (op_fire && op_code == BBALU_OP_ADC |=> // [RULE1]
    res_data == 8'($past(op_dst) + $past(op_src) + {7'h00, $past(flag_c)}))
    else $error("add with carry result wrong");
  chk_add_sum: assert property (op_fire && op_code == BBALU_OP_ADD |=> // [RULE2]
    res_data == 8'($past(op_dst) + $past(op_src)) && res_write)
    else $error("add result wrong");
  chk_add_carry: assert property (op_fire && op_code == BBALU_OP_ADD |=> // [RULE3]
    flag_c == ({1'b0, $past(op_dst)} + {1'b0, $past(op_src)} > 9'h0ff))
    else $error("add carry wrong");
  chk_add_ovf: assert property ((op_fire && (op_code == BBALU_OP_ADD || op_code == BBALU_OP_ADC)) ##1 // [RULE4]
    res_valid |-> flag_v == ($past(op_dst[7]) == $past(op_src[7]) && res_data[7] != $past(op_dst[7])))
    else $error("add overflow wrong");
  chk_add_half: assert property (op_fire && op_code == BBALU_OP_ADD |=> // [RULE5]
    flag_h == ({1'b0, $past(op_dst[3:0])} + {1'b0, $past(op_src[3:0])} > 5'h0f))
    else $error("add half carry wrong");
  chk_add_dec: assert property (op_fire && (op_code == BBALU_OP_ADD || op_code == BBALU_OP_ADC) |=> // [RULE6]
    !flag_d)
    else $error("decimal flag not cleared");
  chk_add_zs: assert property (op_fire && (op_code == BBALU_OP_ADD || op_code == BBALU_OP_ADC) |=> // [RULE7]
    flag_z == (res_data == 8'h00) && flag_s == res_data[7])
    else $error("add zero or sign wrong");
  chk_and_data: assert property (op_fire && op_code == BBALU_OP_AND |=> // [RULE8]
    res_data == ($past(op_dst) & $past(op_src)))
    else $error("and result wrong");
  chk_and_flags: assert property (op_fire && op_code == BBALU_OP_AND |=> // [RULE9]
    !flag_v && flag_s == res_data[7] && flag_z == (res_data == 8'h00) && $stable(flag_c) && $stable(flag_h))
    else $error("and flags wrong");
  chk_band_bits: assert property (op_fire && op_code == BBALU_OP_BAND && !bit_sel |=> // [RULE10]
    res_data[7:1] == $past(op_dst[7:1]) && res_data[0] == ($past(op_dst[0]) & $past(op_src[bit_idx])))
    else $error("bit and result wrong");
  chk_band_flags: assert property (op_fire && op_code == BBALU_OP_BAND |=> // [RULE11]
    !flag_s && $stable(flag_c) && $stable(flag_d) && $stable(flag_h) &&
    flag_z == !(res_data[$past(bit_sel) ? $past(bit_idx) : 3'h0]))
    else $error("bit and flags wrong");
  chk_field_decode: assert property (op_fire && next_valid |=> // [RULE12]
    res_reg_addr == $past(op_bitfield[7:4]))
    else $error("register field wrong");
  chk_bcp_flag: assert property (op_fire && op_code == BBALU_OP_BIT_COMPARE |=> // [RULE13]
    res_valid && !res_write && !flag_s && flag_z == ($past(op_dst[0]) == $past(op_src[bit_idx])))
    else $error("bit compare wrong");
  chk_flags_hold: assert property (!res_valid |-> // [RULE14]
    $stable({flag_c, flag_z, flag_s, flag_v, flag_d, flag_h}))
    else $error("flags moved without result");
  chk_reset_idle: assert property ($rose(rst_sync_b) |-> !res_valid ##1 // [RULE15]
    (!res_valid || $past(op_fire)))
    else $error("result pending after reset");

  cov_adc_carry: cover property (op_fire && op_code == BBALU_OP_ADC && flag_c ##1 flag_c);
  cov_band_hi: cover property (op_fire && op_code == BBALU_OP_BAND && bit_sel);
  cov_bcp_match: cover property (op_fire && op_code == BBALU_OP_BIT_COMPARE ##1 flag_z);
  cov_disable: cover property (op_valid && !op_ready);
endmodule
`default_nettype wire

// *** rtl/bbalu_pkg.sv ***
// Purpose: Shared constants and types for the byte and bit ALU datapath
// Assumes: 8-bit operands, 32-bit AXI4-Lite register slave
// Notes: Register offsets are byte addresses
package bbalu_pkg;
  localparam int BBALU_DATA_W = 8;
  localparam int BBALU_AXI_AW = 4;
  // Operation select from instruction decode
  typedef enum logic [2:0] {
    BBALU_OP_ADD = 3'h0,
    BBALU_OP_ADC = 3'h1,
    BBALU_OP_AND = 3'h2,
    BBALU_OP_BAND = 3'h3,
    BBALU_OP_BIT_COMPARE = 3'h4
  } bbalu_op_t;
  // Second instruction byte of bit-operand forms
  localparam int BBALU_FLD_REG_HI = 7;
  localparam int BBALU_FLD_REG_LO = 4;
  localparam int BBALU_FLD_BIT_HI = 3;
  localparam int BBALU_FLD_BIT_LO = 1;
  localparam int BBALU_FLD_SEL = 0;
  // Register map
  localparam logic [3:0] BBALU_CTRL_OFS = 4'h0;
  localparam logic [3:0] BBALU_STATUS_OFS = 4'h4;
  localparam logic [3:0] BBALU_RESULT_OFS = 4'h8;
  localparam int BBALU_CTRL_EN_BIT = 0;
  localparam logic BBALU_CTRL_EN_RESET = 1'b1;
  // Status bit positions
  localparam int BBALU_ST_C = 7;
  localparam int BBALU_ST_Z = 6;
  localparam int BBALU_ST_S = 5;
  localparam int BBALU_ST_V = 4;
  localparam int BBALU_ST_D = 3;
  localparam int BBALU_ST_H = 2;
  localparam int BBALU_ST_RES = 0;
  localparam logic [1:0] BBALU_RESP_OKAY = 2'h0;
  localparam logic [1:0] BBALU_RESP_SLVERR = 2'h2;
endpackage

// *** tb/bbalu_core_tb.sv ***
// Purpose: Self-checking bench for the byte and bit ALU
// Assumes: One operation in flight; AXI master holds each channel until taken
// Notes: Flag reference kept in ef as c z s v d h
`timescale 1ns/100ps
`default_nettype none
module bbalu_core_tb;
  import bbalu_pkg::*;
  logic sys_clk, rst_b, op_valid, op_ready, res_valid, res_write;
  bbalu_op_t op_code;
  logic [7:0] op_dst, op_src, op_bitfield, res_data, rf_data;
  logic [3:0] res_reg_addr, rf_addr, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic flag_c, flag_z, flag_s, flag_v, flag_d, flag_h;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0] ef;
  int bad_count, n_checks;

  bbalu_core u_dut (.sys_clk, .rst_b, .op_valid, .op_code, .op_dst, .op_src, .op_bitfield, .op_ready,
    .res_valid, .res_write, .res_data, .res_reg_addr, .flag_c, .flag_z, .flag_s, .flag_v, .flag_d, .flag_h,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  bbalu_rf_model u_rf (.sys_clk, .res_valid, .res_write, .res_data, .res_reg_addr, .rf_addr, .rf_data);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task results;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Handshakes judged just after an edge, so the edge itself never races the slave
  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      #1;
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge sys_clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end while (!b_hs);
    s_axi_bready <= 1'b0;
  endtask

  task axi_rd(input logic [3:0] a);
    logic ar_hs, r_hs;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      #1;
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge sys_clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end while (!r_hs);
    s_axi_rready <= 1'b0;
  endtask

  // Reference result and flags worked out before driving the request
  task exec(input bbalu_op_t c, input logic [7:0] d, input logic [7:0] s, input logic [7:0] bf);
    logic [8:0] sum;
    logic [7:0] r;
    logic cin, wr, rdy;
    cin = (c == BBALU_OP_ADC) ? ef[5] : 1'b0;
    sum = d + s + cin;
    r = d;
    wr = 1'b1;
    case (c)
      BBALU_OP_ADD, BBALU_OP_ADC: begin
        r = sum[7:0];
        ef = {sum[8], r == 8'h00, r[7], (d[7] == s[7]) && (r[7] != d[7]), 1'b0, (d[3:0] + s[3:0] + cin) > 5'h0f};
      end
      BBALU_OP_AND: begin
        r = d & s;
        ef[4:2] = {r == 8'h00, r[7], 1'b0};
      end
      BBALU_OP_BAND: begin
        if (bf[0]) r[bf[3:1]] = d[bf[3:1]] & s[0];
        else r[0] = d[0] & s[bf[3:1]];
        ef[4:3] = {~(bf[0] ? r[bf[3:1]] : r[0]), 1'b0};
      end
      default: begin
        wr = 1'b0;
        ef[4:3] = {d[0] == s[bf[3:1]], 1'b0};
      end
    endcase
    rf_addr = bf[7:4];
    @(posedge sys_clk);
    op_code <= c;
    op_dst <= d;
    op_src <= s;
    op_bitfield <= bf;
    op_valid <= 1'b1;
    do begin
      #1;
      rdy = op_ready;
      @(posedge sys_clk);
    end while (rdy !== 1'b1);
    #1;
    op_valid <= 1'b0;
    compare("op status", {1'b1, wr, bf[7:4], ef}, {res_valid, res_write, res_reg_addr,
      flag_c, flag_z, flag_s, flag_v, flag_d, flag_h});
    if (wr) compare("op data", r, res_data);
    @(posedge sys_clk);
    #1;
    if (wr) compare("reg file", r, rf_data);
  endtask

  initial begin
    bad_count = 0;
    n_checks = 0;
    ef = 6'h00;
    rf_addr = 4'h0;
    rst_b = 1'b0;
    op_valid = 1'b0;
    op_code = BBALU_OP_ADD;
    {op_dst, op_src, op_bitfield} = 24'h000000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    compare("reset outputs", 8'h00, {res_valid, res_write, flag_c, flag_z, flag_s, flag_v, flag_d, flag_h});
    $display("test reset done");
    exec(BBALU_OP_ADD, 8'h12, 8'h03, 8'h10);
    exec(BBALU_OP_ADD, 8'h80, 8'h80, 8'h21);
    exec(BBALU_OP_ADD, 8'h01, 8'h01, 8'h31);
    exec(BBALU_OP_ADC, 8'hff, 8'h01, 8'h40);
    exec(BBALU_OP_ADC, 8'h10, 8'h03, 8'h50);
    exec(BBALU_OP_ADD, 8'h0f, 8'h01, 8'h60);
    exec(BBALU_OP_ADD, 8'h7f, 8'h01, 8'h70);
    exec(BBALU_OP_ADD, 8'hf0, 8'h20, 8'h80);
    exec(BBALU_OP_AND, 8'h12, 8'h03, 8'h90);
    exec(BBALU_OP_AND, 8'hf0, 8'h8f, 8'ha0);
    exec(BBALU_OP_AND, 8'h0f, 8'hf0, 8'hb0);
    $display("test byte ops done");
    axi_rd(BBALU_CTRL_OFS);
    compare("ctrl reset", 32'h1, rd);
    axi_rd(BBALU_STATUS_OFS);
    compare("status", {24'h0, ef, 2'b00}, rd);
    axi_rd(BBALU_RESULT_OFS);
    compare("result", 32'h0, rd);
    axi_rd(4'hc);
    compare("unmapped read data", 32'h0, rd);
    compare("unmapped read resp", {30'h0, BBALU_RESP_SLVERR}, {30'h0, rsp});
    axi_wr(4'hc, 32'h0);
    compare("unmapped write", BBALU_RESP_SLVERR, rsp);
    axi_wr(BBALU_CTRL_OFS, 32'h0);
    #1;
    compare("disable", {BBALU_RESP_OKAY, 1'b0}, {rsp, op_ready});
    @(posedge sys_clk);
    op_valid <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    compare("refused op", {1'b0, ef}, {res_valid, flag_c, flag_z, flag_s, flag_v, flag_d, flag_h});
    op_valid <= 1'b0;
    axi_wr(BBALU_CTRL_OFS, 32'h1);
    #1;
    compare("enable", 1'b1, op_ready);
    $display("test register bus done");
    exec(BBALU_OP_BAND, 8'h07, 8'h05, 8'h12);
    exec(BBALU_OP_BAND, 8'h07, 8'h06, 8'h25);
    exec(BBALU_OP_BAND, 8'h01, 8'h80, 8'h3e);
    exec(BBALU_OP_BIT_COMPARE, 8'h07, 8'h01, 8'h22);
    exec(BBALU_OP_BIT_COMPARE, 8'h07, 8'h02, 8'h22);
    compare("reg kept", 8'h03, rf_data);
    $display("test bit ops done");
    results();
  end

  initial begin
    #50000;
    bad_count++;
    results();
  end
endmodule
`default_nettype wire

// *** tb/bbalu_rf_model.sv ***
// Purpose: Working register file on the far side, taking ALU write-backs
// Assumes: A write lands on the edge where res_valid and res_write are high
// Notes: Read port is combinational so the bench can look mid-cycle
`timescale 1ns/100ps
`default_nettype none
module bbalu_rf_model (
  input wire logic sys_clk,
  input wire logic res_valid,
  input wire logic res_write,
  input wire logic [7:0] res_data,
  input wire logic [3:0] res_reg_addr,
  input wire logic [3:0] rf_addr,
  output logic [7:0] rf_data
);
  logic [7:0] regs [16];
  // Bit compare raises no write, so its register must stay put
  always_ff @(posedge sys_clk) begin
    if (res_valid && res_write) begin
      regs[res_reg_addr] <= res_data;
    end
  end
  assign rf_data = regs[rf_addr];
endmodule
`default_nettype wire
